// ==== verilog/hsb_device.sv ====
// Wireless module serial port: input/output buffers, UART, flow control
`timescale 1ns/1ps
module hsb_device #(
   parameter int unsigned IN_DEPTH  = hsb_pkg::IN_BUF_DEPTH,
   parameter int unsigned OUT_DEPTH = hsb_pkg::OUT_BUF_DEPTH,
   parameter int unsigned PKT_MAX   = hsb_pkg::MAX_PACKET
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_sys_rst,
   hsb_link_if.device      link,
   input  wire logic [2:0] i_baud_select,
   input  wire logic       i_baud_load,
   input  wire logic [1:0] i_cts_pin_config,
   input  wire logic [1:0] i_rts_pin_config,
   input  wire logic [7:0] i_packetization_timeout,
   input  wire logic       i_radio_rx_busy,
   input  wire logic       i_radio_rx_valid,
   input  wire logic [7:0] i_radio_rx_data,
   output logic            o_radio_tx_valid,
   output logic      [7:0] o_radio_tx_data,
   output logic            o_radio_tx_last,
   input  wire logic       i_radio_tx_ready,
   output logic            o_radio_rx_drop,
   output logic            o_frame_error
);
   localparam int IAW = $clog2(IN_DEPTH);
   localparam int OAW = $clog2(OUT_DEPTH);

   logic [2:0]  baud_select;
   logic [15:0] bit_cycles;
   assign bit_cycles = hsb_pkg::hsb_bit_cycles(baud_select);

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) baud_select <= hsb_pkg::BAUD_SEL_RESET;
      else if (i_baud_load) baud_select <= i_baud_select;
   end

   // Input synchronisers
   logic rx_s1, rx_s2, rts_s1, rts_s2;
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rx_s1  <= 1'b1;
         rx_s2  <= 1'b1;
         rts_s1 <= 1'b1;
         rts_s2 <= 1'b1;
      end else begin
         rx_s1  <= link.host_to_dev;
         rx_s2  <= rx_s1;
         rts_s1 <= link.rts_n;
         rts_s2 <= rts_s1;
      end
   end

   // Serial receiver
   hsb_pkg::hsb_state_t rx_st;
   logic [15:0] rx_cnt;
   logic [2:0]  rx_bit;
   logic [7:0]  rx_sh;
   logic        rx_done;
   always_ff @(posedge i_core_clk) begin
      rx_done <= 1'b0;
      if (i_sys_rst) begin
         rx_st         <= hsb_pkg::HSB_IDLE;
         rx_cnt        <= 16'h0000;
         rx_bit        <= 3'h0;
         rx_sh         <= 8'h00;
         o_frame_error <= 1'b0;
      end else begin
         o_frame_error <= 1'b0;
         case (rx_st)
            hsb_pkg::HSB_IDLE: if (!rx_s2) begin
               rx_st  <= hsb_pkg::HSB_START;
               rx_cnt <= {1'b0, bit_cycles[15:1]};
            end
            hsb_pkg::HSB_START: if (rx_cnt == 16'h0000) begin
               rx_st  <= rx_s2 ? hsb_pkg::HSB_IDLE : hsb_pkg::HSB_DATA;
               rx_cnt <= bit_cycles - 16'h0001;
               rx_bit <= 3'h0;
            end else rx_cnt <= rx_cnt - 16'h0001;
            hsb_pkg::HSB_DATA: if (rx_cnt == 16'h0000) begin
               rx_sh  <= {rx_s2, rx_sh[7:1]};
               rx_cnt <= bit_cycles - 16'h0001;
               rx_bit <= rx_bit + 3'h1;
               if (rx_bit == 3'h7) rx_st <= hsb_pkg::HSB_STOP;
            end else rx_cnt <= rx_cnt - 16'h0001;
            hsb_pkg::HSB_STOP: if (rx_cnt == 16'h0000) begin
               rx_st         <= hsb_pkg::HSB_IDLE;
               rx_done       <= rx_s2;
               o_frame_error <= !rx_s2;
            end else rx_cnt <= rx_cnt - 16'h0001;
            default: rx_st <= hsb_pkg::HSB_IDLE;
         endcase
      end
   end

   // Host input buffer; ring is a power of two so pointer bits index it directly
   logic [7:0] in_mem [2**IAW];
   logic [IAW:0] in_wp, in_rp, in_used, in_free;
   logic in_push, in_pop, in_full, in_empty;
   assign in_used  = in_wp - in_rp;
   assign in_free  = (IAW+1)'(IN_DEPTH) - in_used;
   assign in_full  = in_used == (IAW+1)'(IN_DEPTH);
   assign in_empty = in_used == '0;
   assign in_push  = rx_done && !in_full;

   // Packetizer: drains only when no radio reception is active
   logic [7:0]  pkt_cnt;
   logic [17:0] idle_cnt;
   logic [17:0] idle_limit;
   // Slowest rate times three overflows 16 bits
   assign idle_limit = 18'(bit_cycles) * 18'(hsb_pkg::PKT_TIMEOUT_BIT);
   logic [7:0]  idle_chars;
   logic        sending;
   assign o_radio_tx_valid = sending && !in_empty && !i_radio_rx_busy;
   assign in_pop           = o_radio_tx_valid && i_radio_tx_ready;
   assign o_radio_tx_data  = in_mem[in_rp[IAW-1:0]];
   assign o_radio_tx_last  = (pkt_cnt == 8'(PKT_MAX - 1)) || (in_used == (IAW+1)'(1));

   always_ff @(posedge i_core_clk) begin
      if (in_push) in_mem[in_wp[IAW-1:0]] <= rx_sh;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         in_wp      <= '0;
         in_rp      <= '0;
         pkt_cnt    <= 8'h00;
         idle_cnt   <= 18'h00000;
         idle_chars <= 8'h00;
         sending    <= 1'b0;
      end else begin
         if (in_push) in_wp <= in_wp + 1'b1;
         if (in_pop) begin
            in_rp   <= in_rp + 1'b1;
            pkt_cnt <= o_radio_tx_last ? 8'h00 : pkt_cnt + 8'h01;
            if (o_radio_tx_last) sending <= 1'b0;
         end
         // Timeout counted in units of three bit times of silence on the input
         if (in_push || rx_st != hsb_pkg::HSB_IDLE) begin
            idle_cnt   <= 18'h00000;
            idle_chars <= 8'h00;
         end else if (idle_cnt >= idle_limit) begin
            idle_cnt <= 18'h00000;
            if (idle_chars != 8'hFF) idle_chars <= idle_chars + 8'h01;
         end else idle_cnt <= idle_cnt + 18'h00001;
         if (!sending && !in_empty &&
             (idle_chars >= i_packetization_timeout ||
              in_used >= (IAW+1)'(PKT_MAX))) sending <= 1'b1;
      end
   end

   // Clear-to-send with hysteresis, active low
   logic cts_n;
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) cts_n <= 1'b0;
      else if (in_free <= (IAW+1)'(hsb_pkg::CTS_OFF_FREE)) cts_n <= 1'b1;
      else if (in_free >= (IAW+1)'(hsb_pkg::CTS_ON_FREE)) cts_n <= 1'b0;
   end
   assign link.cts_n = (i_cts_pin_config == hsb_pkg::CTS_CFG_FLOW) ? cts_n : 1'b0;

   // Host output buffer
   logic [7:0] out_mem [2**OAW];
   logic [OAW:0] out_wp, out_rp;
   logic out_full, out_empty, out_push, out_pop, rts_ok;
   assign out_full  = (out_wp - out_rp) == (OAW+1)'(OUT_DEPTH);
   assign out_empty = out_wp == out_rp;
   assign out_push  = i_radio_rx_valid && !out_full;
   assign o_radio_rx_drop = i_radio_rx_valid && out_full;
   assign rts_ok = (i_rts_pin_config != hsb_pkg::RTS_CFG_FLOW) || !rts_s2;

   hsb_pkg::hsb_state_t tx_st;
   logic [15:0] tx_cnt;
   logic [2:0]  tx_bit;
   logic [7:0]  tx_sh;
   logic        tx_line;
   assign out_pop = tx_st == hsb_pkg::HSB_IDLE && !out_empty && rts_ok;
   assign link.dev_to_host = tx_line;

   always_ff @(posedge i_core_clk) begin
      if (out_push) out_mem[out_wp[OAW-1:0]] <= i_radio_rx_data;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         out_wp  <= '0;
         out_rp  <= '0;
         tx_st   <= hsb_pkg::HSB_IDLE;
         tx_cnt  <= 16'h0000;
         tx_bit  <= 3'h0;
         tx_sh   <= 8'h00;
         tx_line <= 1'b1;
      end else begin
         if (out_push) out_wp <= out_wp + 1'b1;
         case (tx_st)
            hsb_pkg::HSB_IDLE: begin
               tx_line <= 1'b1;
               if (out_pop) begin
                  out_rp  <= out_rp + 1'b1;
                  tx_sh   <= out_mem[out_rp[OAW-1:0]];
                  tx_st   <= hsb_pkg::HSB_START;
                  tx_line <= 1'b0;
                  tx_cnt  <= bit_cycles - 16'h0001;
               end
            end
            hsb_pkg::HSB_START, hsb_pkg::HSB_DATA: if (tx_cnt == 16'h0000) begin
               tx_line <= tx_sh[0];
               tx_sh   <= {1'b0, tx_sh[7:1]};
               tx_cnt  <= bit_cycles - 16'h0001;
               tx_bit  <= (tx_st == hsb_pkg::HSB_START) ? 3'h0 : tx_bit + 3'h1;
               if (tx_st == hsb_pkg::HSB_START) tx_st <= hsb_pkg::HSB_DATA;
               else if (tx_bit == 3'h7) begin
                  tx_st   <= hsb_pkg::HSB_STOP;
                  tx_line <= 1'b1;
               end
            end else tx_cnt <= tx_cnt - 16'h0001;
            hsb_pkg::HSB_STOP: if (tx_cnt == 16'h0000) tx_st <= hsb_pkg::HSB_IDLE;
               else tx_cnt <= tx_cnt - 16'h0001;
            default: tx_st <= hsb_pkg::HSB_IDLE;
         endcase
      end
   end
endmodule : hsb_device

// ==== shared/hsb_pkg.sv ====
// Shared constants and types for the host serial buffered port
package hsb_pkg;
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam logic [2:0]  BAUD_SEL_RESET  = 3'h3;
   localparam int unsigned IN_BUF_DEPTH    = 128;
   localparam int unsigned OUT_BUF_DEPTH   = 128;
   localparam int unsigned CTS_OFF_FREE    = 17;
   localparam int unsigned CTS_ON_FREE     = 34;
   localparam int unsigned MAX_PACKET      = 100;
   localparam int unsigned PKT_TIMEOUT_BIT = 3;
   localparam int unsigned DATA_BITS       = 8;
   localparam logic [1:0]  CTS_CFG_FLOW    = 2'h1;
   localparam logic [1:0]  RTS_CFG_FLOW    = 2'h1;

   typedef enum logic [1:0] {HSB_IDLE, HSB_START, HSB_DATA, HSB_STOP} hsb_state_t;

   // Bit period in clock cycles for each baud selection code
   function automatic logic [15:0] hsb_bit_cycles(input logic [2:0] sel);
      logic [31:0] bps;
      case (sel)
         3'h0:    bps = 32'd1200;
         3'h1:    bps = 32'd2400;
         3'h2:    bps = 32'd4800;
         3'h3:    bps = 32'd9600;
         3'h4:    bps = 32'd19200;
         3'h5:    bps = 32'd38400;
         3'h6:    bps = 32'd57600;
         default: bps = 32'd115200;
      endcase
      hsb_bit_cycles = 16'(CLK_HZ / bps);
   endfunction : hsb_bit_cycles
endpackage : hsb_pkg

// ==== shared/hsb_link_if.sv ====
// Serial link between the host and the wireless module
`timescale 1ns/1ps
interface hsb_link_if;
   logic host_to_dev;
   logic dev_to_host;
   logic cts_n;
   logic rts_n;
   modport device (input host_to_dev, input rts_n, output dev_to_host, output cts_n);
   modport host (output host_to_dev, output rts_n, input dev_to_host, input cts_n);
endinterface : hsb_link_if

// ==== verilog/hsb_host.sv ====
// Host end: UART that honours clear-to-send and drives request-to-send
`timescale 1ns/1ps
module hsb_host (
   input  wire logic       i_core_clk,
   input  wire logic       i_sys_rst,
   hsb_link_if.host        link,
   input  wire logic [2:0] i_baud_select,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic            o_tx_ready,
   input  wire logic       i_rx_ready,
   output logic            o_rx_valid,
   output logic      [7:0] o_rx_data,
   output logic            o_frame_error
);
   logic [15:0] bit_cycles;
   assign bit_cycles = hsb_pkg::hsb_bit_cycles(i_baud_select);
   assign link.rts_n = !i_rx_ready;

   logic rx_s1, rx_s2, cts_s1, cts_s2;
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rx_s1  <= 1'b1;
         rx_s2  <= 1'b1;
         cts_s1 <= 1'b1;
         cts_s2 <= 1'b1;
      end else begin
         rx_s1  <= link.dev_to_host;
         rx_s2  <= rx_s1;
         cts_s1 <= link.cts_n;
         cts_s2 <= cts_s1;
      end
   end

   // Transmitter: 10 bit times per byte, line idles high
   logic [9:0]  tx_sh;
   logic [3:0]  tx_left;
   logic [15:0] tx_cnt;
   assign o_tx_ready = tx_left == 4'h0 && !cts_s2;
   assign link.host_to_dev = tx_sh[0];
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         tx_sh   <= 10'h3FF;
         tx_left <= 4'h0;
         tx_cnt  <= 16'h0000;
      end else if (tx_left == 4'h0) begin
         if (i_tx_valid && o_tx_ready) begin
            tx_sh   <= {1'b1, i_tx_data, 1'b0};
            tx_left <= 4'hA;
            tx_cnt  <= bit_cycles - 16'h0001;
         end
      end else if (tx_cnt == 16'h0000) begin
         tx_sh   <= {1'b1, tx_sh[9:1]};
         tx_left <= tx_left - 4'h1;
         tx_cnt  <= bit_cycles - 16'h0001;
      end else tx_cnt <= tx_cnt - 16'h0001;
   end

   // Receiver: samples mid-bit, stop bit checked
   logic [3:0]  rx_left;
   logic [15:0] rx_cnt;
   logic [8:0]  rx_sh;
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rx_left       <= 4'h0;
         rx_cnt        <= 16'h0000;
         rx_sh         <= 9'h000;
         o_rx_valid    <= 1'b0;
         o_rx_data     <= 8'h00;
         o_frame_error <= 1'b0;
      end else begin
         o_rx_valid    <= 1'b0;
         o_frame_error <= 1'b0;
         if (rx_left == 4'h0) begin
            if (!rx_s2) begin
               rx_left <= 4'hA;
               rx_cnt  <= {1'b0, bit_cycles[15:1]};
            end
         end else if (rx_cnt == 16'h0000) begin
            rx_sh   <= {rx_s2, rx_sh[8:1]};
            rx_cnt  <= bit_cycles - 16'h0001;
            rx_left <= rx_left - 4'h1;
            if (rx_left == 4'hA && rx_s2) rx_left <= 4'h0;
            if (rx_left == 4'h1) begin
               o_rx_valid    <= rx_s2;
               o_rx_data     <= rx_sh[8:1];
               o_frame_error <= !rx_s2;
            end
         end else rx_cnt <= rx_cnt - 16'h0001;
      end
   end
endmodule : hsb_host

// ==== sim/hsb_link_asserts.sv ====
// Link checker watching the serial wires between host and device ends
`timescale 1ns/1ps
module hsb_link_asserts #(
   parameter int BIT = 434
) (
   input  wire logic i_core_clk,
   input  wire logic i_sys_rst,
   input  wire logic host_to_dev,
   input  wire logic dev_to_host,
   input  wire logic cts_n,
   input  wire logic rts_n,
   input  wire logic rts_gate_on
);
   localparam int STOP = BIT * 19 / 2;
   localparam int HALF = BIT / 2;
   logic        h_prev;
   logic        d_prev;
   logic [15:0] h_run;
   logic [15:0] d_run;
   logic [12:0] h_pos;
   wire  [15:0] next_h_run;
   wire  [15:0] next_d_run;
   wire  [12:0] next_h_pos;
   // Run lengths saturate so a long idle never wraps
   assign next_h_run = (host_to_dev != h_prev) ? 16'h1 : h_run + {15'h0, h_run != 16'hFFFF};
   assign next_d_run = (dev_to_host != d_prev) ? 16'h1 : d_run + {15'h0, d_run != 16'hFFFF};
   // Frame position on the host line, counted from the start edge
   assign next_h_pos = (h_pos != 13'h0) ? ((h_pos == 13'(STOP)) ? 13'h0 : h_pos + 13'h1)
                                        : {12'h0, h_prev & ~host_to_dev};
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         h_prev <= 1'b1;
         d_prev <= 1'b1;
         h_run  <= 16'hFFFF;
         d_run  <= 16'hFFFF;
         h_pos  <= 13'h0;
      end else begin
         h_prev <= host_to_dev;
         d_prev <= dev_to_host;
         h_run  <= next_h_run;
         d_run  <= next_d_run;
         h_pos  <= next_h_pos;
      end
   end
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);
   reset_idle_a: assert property (disable iff (1'b0) i_sys_rst |=> host_to_dev && dev_to_host && !cts_n)
      else $error("link not idle after reset");
   host_bit_a: assert property (host_to_dev != h_prev |-> h_run >= 16'(BIT - 1))
      else $error("host line bit too short");
   dev_bit_a: assert property (dev_to_host != d_prev |-> d_run >= 16'(BIT - 1))
      else $error("device line bit too short");
   host_start_a: assert property (h_pos == 13'(HALF) |-> !host_to_dev)
      else $error("start bit not low");
   host_stop_a: assert property (h_pos == 13'(STOP) |-> host_to_dev)
      else $error("stop bit not high");
   cts_hold_a: assert property (h_prev && !host_to_dev && h_pos == 13'h0 |-> !$past(cts_n))
      else $error("host started while clear-to-send off");
   rts_gate_a: assert property (rts_gate_on && d_prev && !dev_to_host && d_run > 16'(10 * BIT)
                                |-> !$past(rts_n))
      else $error("device sent while request-to-send off");
   cts_rise_a: assert property ($rose(cts_n) |-> host_to_dev)
      else $error("clear-to-send dropped outside a stop bit");
endmodule : hsb_link_asserts

// ==== sim/test_host_serial_buffered_port.sv ====
// Bench joining the device and host ends over one serial link
`timescale 1ns/1ps
module test_host_serial_buffered_port;
   localparam int BIT = hsb_pkg::CLK_HZ / 115200;
   logic       clk     = 1'b0;
   logic       rst     = 1'b1;
   logic [2:0] baud    = 3'h3;
   logic       baud_ld = 1'b0;
   logic       busy    = 1'b0;
   logic       rv      = 1'b0;
   logic [7:0] rd      = 8'h00;
   logic       tr      = 1'b1;
   logic       hv      = 1'b0;
   logic [7:0] hd      = 8'h00;
   logic       rx_rdy  = 1'b1;
   logic [1:0] cts_cfg = 2'h1;
   logic [1:0] rts_cfg = 2'h1;
   logic       fe_dev;
   logic       fe_host;
   int         ferrs = 0;
   logic       tv;
   logic [7:0] td;
   logic       tl;
   logic       drop;
   logic       hrdy;
   logic       rxv;
   logic [7:0] rxd;
   int         errors = 0;
   int         total_checks = 0;
   int         drops = 0;
   logic [7:0] rq[$];
   logic [8:0] tq[$];
   hsb_link_if link ();
   hsb_device #(.IN_DEPTH(34), .OUT_DEPTH(2), .PKT_MAX(4)) hsb_device_i (
      .i_core_clk(clk), .i_sys_rst(rst), .link(link), .i_baud_select(baud),
      .i_baud_load(baud_ld), .i_cts_pin_config(cts_cfg), .i_rts_pin_config(rts_cfg),
      .i_packetization_timeout(8'h00), .i_radio_rx_busy(busy), .i_radio_rx_valid(rv),
      .i_radio_rx_data(rd), .o_radio_tx_valid(tv), .o_radio_tx_data(td),
      .o_radio_tx_last(tl), .i_radio_tx_ready(tr), .o_radio_rx_drop(drop),
      .o_frame_error(fe_dev));
   hsb_host hsb_host_i (
      .i_core_clk(clk), .i_sys_rst(rst), .link(link), .i_baud_select(baud),
      .i_tx_valid(hv), .i_tx_data(hd), .o_tx_ready(hrdy), .i_rx_ready(rx_rdy),
      .o_rx_valid(rxv), .o_rx_data(rxd), .o_frame_error(fe_host));
   hsb_link_asserts #(.BIT(BIT)) hsb_link_asserts_i (
      .i_core_clk(clk), .i_sys_rst(rst), .host_to_dev(link.host_to_dev),
      .dev_to_host(link.dev_to_host), .cts_n(link.cts_n), .rts_n(link.rts_n),
      .rts_gate_on(rts_cfg == 2'h1));
   always #10 clk = ~clk;
   // Inputs move only at rising edges, so falling-edge values are what the design takes
   always @(negedge clk) begin
      if (rxv === 1'b1) rq.push_back(rxd);
      if (tv === 1'b1 && tr === 1'b1) tq.push_back({tl, td});
      if (drop === 1'b1) drops++;
      if (fe_dev === 1'b1 || fe_host === 1'b1) ferrs++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic push(input logic [7:0] b);
      @(posedge clk);
      rv <= 1'b1;
      rd <= b;
      @(posedge clk);
      rv <= 1'b0;
   endtask : push
   task automatic offer(input logic [7:0] b);
      @(posedge clk);
      hv <= 1'b1;
      hd <= b;
   endtask : offer
   task automatic take();
      @(negedge clk);
      while (hrdy !== 1'b1) @(negedge clk);
      @(posedge clk);
      hv <= 1'b0;
   endtask : take
   task automatic wait_q(input int n, input int lim, input bit of_tx);
      int k;
      k = 0;
      while ((of_tx ? tq.size() : rq.size()) < n && k < lim) begin
         @(posedge clk);
         k++;
      end
   endtask : wait_q
   task automatic t_baud_default();
      int n;
      // Request-to-send off but not configured for gating: output still flows
      rts_cfg <= 2'h0;
      rx_rdy <= 1'b0;
      push(8'h01);
      n = 0;
      while (link.dev_to_host !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (link.dev_to_host === 1'b0 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      chk(n, hsb_pkg::CLK_HZ / 9600);
      // Cut the slow frame short with a second reset, then go to the fast rate
      @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rts_cfg <= 2'h1;
      baud <= 3'h7;
      baud_ld <= 1'b1;
      @(posedge clk);
      baud_ld <= 1'b0;
      rq.delete();
   endtask : t_baud_default
   task automatic t_out_path();
      @(posedge clk);
      rx_rdy <= 1'b0;
      repeat (4) @(posedge clk);
      push(8'hA5);
      push(8'h3C);
      push(8'h81);
      push(8'h7E);
      repeat (2 * BIT) @(posedge clk);
      chk(rq.size(), 0);
      chk(drops, 2);
      rx_rdy <= 1'b1;
      wait_q(2, 25 * BIT, 1'b0);
      repeat (BIT) @(posedge clk);
      chk(rq.size(), 2);
      chk(rq[0], 8'hA5);
      chk(rq[1], 8'h3C);
   endtask : t_out_path
   task automatic t_flow();
      busy <= 1'b1;
      for (int i = 0; i < 17; i++) begin
         offer(8'h80 | 8'(i));
         take();
         if (i == 16) chk(link.cts_n, 1'b0);
      end
      repeat (10 * BIT) @(posedge clk);
      chk(link.cts_n, 1'b1);
      // Without flow configuration the pin stays asserted
      cts_cfg <= 2'h0;
      repeat (2) @(posedge clk);
      chk(link.cts_n, 1'b0);
      cts_cfg <= 2'h1;
      repeat (4) @(posedge clk);
      chk(tq.size(), 0);
      offer(8'h91);
      repeat (2 * BIT) @(posedge clk);
      chk(link.host_to_dev, 1'b1);
      busy <= 1'b0;
      take();
      chk(link.cts_n, 1'b0);
      wait_q(18, 15 * BIT, 1'b1);
      chk(tq.size(), 18);
      for (int i = 0; i < 18; i++) begin
         chk(tq[i], {(i % 4 == 3) || (i >= 16), 8'h80 | 8'(i)});
      end
      chk(ferrs, 0);
   endtask : t_flow
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_baud_default();
      t_out_path();
      t_flow();
      end_sim();
   end
   initial begin
      repeat (110000) @(posedge clk);
      errors++;
      end_sim();
   end
endmodule : test_host_serial_buffered_port
